// file: rtl/wwdg_params.svh
// Constants of the window watchdog: register offsets, field positions,
// reset values and timing figures.
// Assumes the block clock runs at 10 MHz and the bus carries 8-bit data.
`ifndef WWDG_PARAMS_SVH
`define WWDG_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WWDG_OFS_CTRL 8'h2f
`define WWDG_OFS_WIN 8'h30
`define WWDG_OFS_STAT 8'h31
`define WWDG_OFS_MIN_LO 8'h32
`define WWDG_OFS_MIN_MID 8'h33
`define WWDG_OFS_MIN_HI 8'h34
`define WWDG_OFS_MAX_LO 8'h35
`define WWDG_OFS_MAX_MID 8'h36
`define WWDG_OFS_MAX_HI 8'h37

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define WWDG_ACT_BIT 7
`define WWDG_TOP_BIT 6
`define WWDG_CNT_RST 7'h7f
`define WWDG_WIN_RST 7'h7f
`define WWDG_ROLL_FROM 7'h40
`define WWDG_CNT_WRAP 7'h7f

// ****************************************************************
// Timeout arithmetic
// ****************************************************************
`define WWDG_DECR_PERIOD 16384
`define WWDG_ADJ_UNIT 64
`define WWDG_ADJ_BASE 192
`define WWDG_MIN0_OFS 128
`define WWDG_ACC_STEP 7'h04
`define WWDG_TB0_MSB 6'h04
`define WWDG_TB0_LSB 6'h3b
`define WWDG_TB1_MSB 6'h08
`define WWDG_TB1_LSB 6'h35
`define WWDG_TB2_MSB 6'h14
`define WWDG_TB2_LSB 6'h23
`define WWDG_TB3_MSB 6'h31
`define WWDG_TB3_LSB 6'h36

// ****************************************************************
// Timing
// ****************************************************************
`define WWDG_CLK_NS 100
`define WWDG_RST_PULSE_NS 30000
`define WWDG_RST_PULSE_CYC ((`WWDG_RST_PULSE_NS + `WWDG_CLK_NS - 1) / `WWDG_CLK_NS)
`define WWDG_DLY_SHORT_CYC 256
`define WWDG_DLY_LONG_CYC 4096

`endif

// file: rtl/wwdg_pkg.sv
// Types shared by the window watchdog files.
// Assumes wwdg_params.svh supplies all numeric constants.
package wwdg_pkg;

    typedef enum logic [2:0] {
        WWDG_BOOT,
        WWDG_RUN,
        WWDG_HALT_STOP,
        WWDG_ACTIVE_HALT,
        WWDG_RESTART_WAIT
    } wwdg_state_t;

    typedef logic [23:0] wwdg_cycles_t;

    typedef struct packed {
        logic [5:0] msb;
        logic [5:0] lsb;
    } wwdg_coef_t;

endpackage

// file: rtl/wwdg_calc_if.sv
// Carrier between the watchdog core and its timeout calculator.
// Assumes both ends sit on the same clock; it holds no state.
`timescale 1ns/1ps
interface wwdg_calc_if;
    logic [1:0] tb_sel;
    logic [5:0] cnt;
    wwdg_pkg::wwdg_coef_t coef;
    wwdg_pkg::wwdg_cycles_t min_cyc;
    wwdg_pkg::wwdg_cycles_t max_cyc;

    modport calc (input tb_sel, input cnt, output coef, output min_cyc, output max_cyc);
    modport user (output tb_sel, output cnt, input coef, input min_cyc, input max_cyc);
endinterface

// file: rtl/wwdg_timeout_calc.sv
// Prescaler coefficients and exact timeout bounds for a reload count.
// Assumes the time base select and count are stable within a cycle.
`timescale 1ns/1ps
`include "wwdg_params.svh"
module wwdg_timeout_calc #(
    parameter int DECR_PERIOD = `WWDG_DECR_PERIOD,
    parameter int ADJ_UNIT = `WWDG_ADJ_UNIT
) (
    wwdg_calc_if.calc bus
);

    function automatic wwdg_pkg::wwdg_coef_t coef_of(input logic [1:0] tb);
        wwdg_pkg::wwdg_coef_t c;
        c = '{msb: `WWDG_TB0_MSB, lsb: `WWDG_TB0_LSB};
        case (tb)
            2'h1: c = '{msb: `WWDG_TB1_MSB, lsb: `WWDG_TB1_LSB};
            2'h2: c = '{msb: `WWDG_TB2_MSB, lsb: `WWDG_TB2_LSB};
            2'h3: c = '{msb: `WWDG_TB3_MSB, lsb: `WWDG_TB3_LSB};
            default: c = '{msb: `WWDG_TB0_MSB, lsb: `WWDG_TB0_LSB};
        endcase
        return c;
    endfunction

    // Integer division truncates, which is exactly the floor wanted here.
    wire wwdg_pkg::wwdg_coef_t coef = coef_of(bus.tb_sel);
    wire [31:0] cnt_w = {26'h0, bus.cnt};
    wire [31:0] msb_w = {26'h0, coef.msb};
    wire [31:0] lsb_w = {26'h0, coef.lsb};
    wire [31:0] split_w = (cnt_w << 2) / msb_w;
    wire [31:0] knee_w = msb_w >> 2;
    wire [31:0] min0_w = (lsb_w + `WWDG_MIN0_OFS) * ADJ_UNIT;
    wire [31:0] max0_w = DECR_PERIOD;
    wire [31:0] simple_w = DECR_PERIOD * cnt_w;
    wire [31:0] split_sum_w = DECR_PERIOD * (cnt_w - split_w) + (`WWDG_ADJ_BASE + lsb_w) * ADJ_UNIT * split_w;
    wire [31:0] min_w = (cnt_w < knee_w) ? min0_w + simple_w : min0_w + split_sum_w;
    wire [31:0] max_w = (cnt_w <= knee_w) ? max0_w + simple_w : max0_w + split_sum_w;

    assign bus.coef = coef;
    assign bus.min_cyc = min_w[23:0];
    assign bus.max_cyc = max_w[23:0];

endmodule

// file: rtl/wwdg_top.sv
// Window watchdog core: free-running downcounter, window check, reset pulse,
// halt handling and a small register port.
// Assumes a synchronous system reset and control inputs from the same clock.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "wwdg_params.svh"
module wwdg_top #(
    parameter int DECR_PERIOD = `WWDG_DECR_PERIOD,
    parameter int ADJ_UNIT = `WWDG_ADJ_UNIT
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [1:0] time_base_select_i,
    input wire logic time_base_irq_enable_i,
    input wire logic halt_reset_option_i,
    input wire logic hw_watchdog_option_i,
    input wire logic long_restart_delay_i,
    input wire logic halt_request_i,
    input wire logic wake_irq_i,
    output logic reset_pin_n_o,
    output logic halt_entered_o
);

    localparam int PW = $clog2(DECR_PERIOD + 1);
    localparam int DW = $clog2(`WWDG_DLY_LONG_CYC + 1);
    localparam int RW = $clog2(`WWDG_RST_PULSE_CYC + 1);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The adjusted step must never outlast the nominal period, or the
    // prescaler register would be too narrow for it.
    if (ADJ_UNIT * (`WWDG_ADJ_BASE + 63) > DECR_PERIOD) begin : g_bad_unit
        $error("Adjusted prescaler step exceeds the nominal period.");
    end
    if (DECR_PERIOD < 2) begin : g_bad_period
        $error("Prescaler period too short.");
    end

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    logic act_q;
    logic [6:0] count_q;
    logic [6:0] win_q;
    logic [PW-1:0] presc_q;
    logic [6:0] acc_q;
    logic [DW-1:0] delay_q;
    logic [RW-1:0] pulse_q;
    logic reset_pin_n_q;
    logic halted_q;
    logic [7:0] rdata_q;
    wwdg_pkg::wwdg_state_t state_q;
    wwdg_pkg::wwdg_state_t state_d;
    logic [DW-1:0] delay_d;

    wwdg_calc_if calc_bus();

    wwdg_timeout_calc #(
        .DECR_PERIOD(DECR_PERIOD),
        .ADJ_UNIT(ADJ_UNIT)
    ) u_calc (
        .bus(calc_bus.calc)
    );

    assign calc_bus.tb_sel = time_base_select_i;
    assign calc_bus.cnt = count_q[5:0];

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire wr_ctrl = reg_write_i && hit(reg_addr_i, `WWDG_OFS_CTRL);
    wire wr_win = reg_write_i && hit(reg_addr_i, `WWDG_OFS_WIN);
    wire enabled = act_q || hw_watchdog_option_i;
    wire act_new = act_q || reg_wdata_i[`WWDG_ACT_BIT];
    wire enabled_new = act_new || hw_watchdog_option_i;
    wire in_run = state_q == wwdg_pkg::WWDG_RUN;
    wire in_hstop = state_q == wwdg_pkg::WWDG_HALT_STOP;
    wire in_ahalt = state_q == wwdg_pkg::WWDG_ACTIVE_HALT;
    wire in_rwait = state_q == wwdg_pkg::WWDG_RESTART_WAIT;

    // ****************************************************************
    // Prescaler
    // ****************************************************************
    // The accumulator spreads the shortened steps so that over n steps
    // exactly floor(4n/MSB) of them are adjusted ones.
    wire [6:0] acc_sum = acc_q + `WWDG_ACC_STEP;
    wire adj_step = acc_sum >= {1'b0, calc_bus.coef.msb};
    wire [31:0] adj_len_w = (`WWDG_ADJ_BASE + {26'h0, calc_bus.coef.lsb}) * ADJ_UNIT;
    wire [31:0] nom_len_w = DECR_PERIOD;
    wire [PW-1:0] step_len = adj_step ? adj_len_w[PW-1:0] : nom_len_w[PW-1:0];
    wire presc_wrap = presc_q == '0;
    wire [PW-1:0] presc_d = presc_wrap ? PW'(step_len - 1'b1) : PW'(presc_q - 1'b1);
    wire [6:0] acc_d = !presc_wrap ? acc_q : adj_step ? acc_sum - {1'b0, calc_bus.coef.msb} : acc_sum;

    // ****************************************************************
    // Counter and reset causes
    // ****************************************************************
    // Slow and wait modes do not reach this block: the count follows the
    // block clock alone, never the processor clock.
    wire halt_plain = in_run && halt_request_i && !time_base_irq_enable_i && !halt_reset_option_i;
    wire halt_fire = in_run && halt_request_i && !time_base_irq_enable_i && halt_reset_option_i;
    wire dec_tick = (presc_wrap && in_run) || halt_plain;
    wire roll_fire = enabled && dec_tick && count_q == `WWDG_ROLL_FROM;
    wire top_fire = wr_ctrl && enabled_new && !reg_wdata_i[`WWDG_TOP_BIT];
    wire win_fire = wr_ctrl && enabled && count_q > win_q;
    wire fire = roll_fire || top_fire || win_fire || halt_fire;
    wire [6:0] count_d = wr_ctrl ? reg_wdata_i[6:0] : dec_tick ? count_q - 7'h01 : count_q;
    wire [RW-1:0] pulse_max = RW'(`WWDG_RST_PULSE_CYC);
    wire [RW-1:0] pulse_d = fire ? pulse_max : (pulse_q != '0) ? RW'(pulse_q - 1'b1) : pulse_q;
    wire [DW-1:0] dly_short = DW'(`WWDG_DLY_SHORT_CYC - 1);
    wire [DW-1:0] dly_long = DW'(`WWDG_DLY_LONG_CYC - 1);
    wire [DW-1:0] dly_load = long_restart_delay_i ? dly_long : dly_short;

    // ****************************************************************
    // Halt state machine
    // ****************************************************************
    // Boot enters the restart wait, so a reset that ends active halt (or
    // any other reset) holds the counter for the configured delay.
    always_comb begin
        state_d = state_q;
        delay_d = (delay_q != '0) ? DW'(delay_q - 1'b1) : delay_q;
        case (state_q)
            wwdg_pkg::WWDG_BOOT: begin
                state_d = wwdg_pkg::WWDG_RESTART_WAIT;
                delay_d = dly_load;
            end
            wwdg_pkg::WWDG_RUN: begin
                if (halt_request_i && time_base_irq_enable_i) begin
                    state_d = wwdg_pkg::WWDG_ACTIVE_HALT;
                end else if (halt_plain) begin
                    state_d = wwdg_pkg::WWDG_HALT_STOP;
                end
            end
            wwdg_pkg::WWDG_HALT_STOP: begin
                if (wake_irq_i) begin
                    state_d = wwdg_pkg::WWDG_RESTART_WAIT;
                    delay_d = dly_load;
                end
            end
            wwdg_pkg::WWDG_ACTIVE_HALT: begin
                if (wake_irq_i) begin
                    state_d = wwdg_pkg::WWDG_RUN;
                end
            end
            wwdg_pkg::WWDG_RESTART_WAIT: begin
                if (delay_q == '0) begin
                    state_d = wwdg_pkg::WWDG_RUN;
                end
            end
            default: begin
                state_d = wwdg_pkg::WWDG_BOOT;
            end
        endcase
    end

    // ****************************************************************
    // Register read
    // ****************************************************************
    wire [7:0] stat_w = {4'h0, enabled, in_hstop, in_ahalt, in_rwait};
    wire [7:0] rd_mux =
        hit(reg_addr_i, `WWDG_OFS_CTRL) ? {act_q, count_q} :
        hit(reg_addr_i, `WWDG_OFS_WIN) ? {1'b0, win_q} :
        hit(reg_addr_i, `WWDG_OFS_STAT) ? stat_w :
        hit(reg_addr_i, `WWDG_OFS_MIN_LO) ? calc_bus.min_cyc[7:0] :
        hit(reg_addr_i, `WWDG_OFS_MIN_MID) ? calc_bus.min_cyc[15:8] :
        hit(reg_addr_i, `WWDG_OFS_MIN_HI) ? calc_bus.min_cyc[23:16] :
        hit(reg_addr_i, `WWDG_OFS_MAX_LO) ? calc_bus.max_cyc[7:0] :
        hit(reg_addr_i, `WWDG_OFS_MAX_MID) ? calc_bus.max_cyc[15:8] :
        hit(reg_addr_i, `WWDG_OFS_MAX_HI) ? calc_bus.max_cyc[23:16] : 8'h00;

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            act_q <= 1'b0;
            count_q <= `WWDG_CNT_RST;
            win_q <= `WWDG_WIN_RST;
            presc_q <= '0;
            acc_q <= 7'h00;
        end else begin
            act_q <= wr_ctrl ? act_new : act_q;
            count_q <= count_d;
            win_q <= wr_win ? reg_wdata_i[6:0] : win_q;
            presc_q <= presc_d;
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= wwdg_pkg::WWDG_BOOT;
            delay_q <= '0;
            pulse_q <= '0;
            reset_pin_n_q <= 1'b1;
            halted_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            delay_q <= delay_d;
            pulse_q <= pulse_d;
            reset_pin_n_q <= pulse_d == '0;
            halted_q <= state_d == wwdg_pkg::WWDG_HALT_STOP || state_d == wwdg_pkg::WWDG_ACTIVE_HALT;
            rdata_q <= reg_read_i ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reset_pin_n_o = reset_pin_n_q;
    assign halt_entered_o = halted_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence seq_plain_wake_short;
        in_hstop && wake_irq_i && !long_restart_delay_i;
    endsequence

    sequence seq_restart_done;
        in_rwait ##1 in_run;
    endsequence

    AST_ROLL_FIRE: assert property (roll_fire |=> !reset_pin_n_q)
        else $error("Roll from 40h did not pull the reset pin.");
    AST_PULSE_LEN: assert property ($fell(reset_pin_n_q) |-> ##299 !reset_pin_n_q)
        else $error("Reset pulse shorter than required.");
    AST_WIN_RELOAD: assert property (wr_ctrl && enabled && count_q > win_q |=> !reset_pin_n_q)
        else $error("Early reload did not reset.");
    AST_TOP_BIT_WRITE: assert property (top_fire |=> !reset_pin_n_q && count_q[`WWDG_TOP_BIT] == 1'b0)
        else $error("Clearing the top bit did not reset.");
    AST_ACT_STICKY: assert property (act_q |=> act_q)
        else $error("Activation bit cleared without reset.");
    AST_HALT_RESET: assert property (halt_fire |=> !reset_pin_n_q && in_run)
        else $error("Halt with reset option entered halt.");
    AST_HALT_ONCE: assert property (halt_plain && !wr_ctrl |=> in_hstop && count_q == $past(count_q) - 7'h01)
        else $error("Plain halt did not decrement exactly once.");
    AST_HSTOP_FROZEN: assert property (in_hstop && !wr_ctrl |=> count_q == $past(count_q))
        else $error("Counter moved during halt.");
    AST_AHALT_FROZEN: assert property (in_ahalt && !wake_irq_i && !wr_ctrl |=> in_ahalt && $stable(count_q))
        else $error("Counter moved during active halt.");
    AST_AHALT_WAKE: assert property (in_ahalt && wake_irq_i |=> in_run)
        else $error("Active halt did not restart at once.");
    AST_RESTART_DELAY: assert property (seq_plain_wake_short |-> ##256 seq_restart_done)
        else $error("Restart delay after halt wake is wrong.");
    AST_HW_ENABLE: assert property (hw_watchdog_option_i && dec_tick && count_q == `WWDG_ROLL_FROM
        |=> !reset_pin_n_q)
        else $error("Hardware option did not keep watchdog active.");
    AST_PRESC_FREE: assert property (wr_ctrl && !presc_wrap |=> presc_q == $past(presc_q) - 1'b1)
        else $error("Reload disturbed the prescaler.");
    AST_BOUNDS: assert property (calc_bus.max_cyc >= calc_bus.min_cyc)
        else $error("Timeout maximum below minimum.");

endmodule

// file: verification/test_window_watchdog_timeout_halt.sv
// Self-checking bench for the window watchdog core and its timeout bounds.
// Assumes the core is built with a shortened decrement period through its parameters.
`timescale 1ns/1ps
module test_window_watchdog_timeout_halt;
    localparam int DP = 4096;
    localparam int AU = 16;
    logic clock_i, reset_i, reg_write_i, reg_read_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [1:0] time_base_select_i;
    logic time_base_irq_enable_i, halt_reset_option_i, hw_watchdog_option_i, long_restart_delay_i;
    logic halt_request_i, wake_irq_i, reset_pin_n_o, halt_entered_o;
    int bad_count = 0;
    int checks_done = 0;
    int seed = 21;
    int cycles = 0;
    int cnt;
    int msb_tab[4] = '{4, 8, 20, 49};
    int lsb_tab[4] = '{59, 53, 35, 54};
    logic [7:0] c1, c2, st;
    logic [47:0] bb;

    wwdg_top #(.DECR_PERIOD(DP), .ADJ_UNIT(AU)) dut (.clock_i(clock_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .time_base_select_i(time_base_select_i),
        .time_base_irq_enable_i(time_base_irq_enable_i), .halt_reset_option_i(halt_reset_option_i),
        .hw_watchdog_option_i(hw_watchdog_option_i), .long_restart_delay_i(long_restart_delay_i),
        .halt_request_i(halt_request_i), .wake_irq_i(wake_irq_i), .reset_pin_n_o(reset_pin_n_o),
        .halt_entered_o(halt_entered_o));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // ****************************************************************
    // Reference model and checking
    // ****************************************************************
    // Integer division truncates, which is exactly the floor the bounds need.
    function automatic int bound(input int tb, input int c, input bit mx);
        int m;
        int l;
        int k;
        int b;
        m = msb_tab[tb];
        l = lsb_tab[tb];
        b = mx ? DP : (l + 128) * AU;
        k = (4 * c) / m;
        if (mx ? (c <= m / 4) : (c < m / 4)) begin
            return b + DP * c;
        end
        return b + DP * (c - k) + (192 + l) * AU * k;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            stop_test();
        end
    end

    // ****************************************************************
    // Bus and pin drivers
    // ****************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_write_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_read_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask

    task automatic pulse(input bit wake);
        @(posedge clock_i);
        halt_request_i <= !wake;
        wake_irq_i <= wake;
        @(posedge clock_i);
        halt_request_i <= 1'b0;
        wake_irq_i <= 1'b0;
    endtask

    task automatic do_reset(input logic hw, input logic long_dly);
        @(posedge clock_i);
        reset_i <= 1'b1;
        hw_watchdog_option_i <= hw;
        long_restart_delay_i <= long_dly;
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        repeat (300) @(posedge clock_i);
    endtask

    task automatic wait_for(input bit on_pin, input logic lvl, input int lim);
        int n;
        n = 0;
        #1;
        while (((on_pin ? reset_pin_n_o : halt_entered_o) !== lvl) && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check(on_pin ? "reset pin" : "halt flag", {31'h0, lvl}, {31'h0, on_pin ? reset_pin_n_o : halt_entered_o});
    endtask

    task automatic expect_fire(input int lim);
        int n;
        wait_for(1'b1, 1'b0, lim);
        n = 0;
        while (reset_pin_n_o === 1'b0 && n < 400) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check("reset pulse length", 300, n);
    endtask

    // The count is read just before the halt so the single decrement can be seen.
    task automatic halt_cycle(input logic irq, input logic [7:0] st_halt, input logic [7:0] st_wake, input int dec);
        time_base_irq_enable_i <= irq;
        wr(8'h2f, 8'h7f);
        rd(8'h2f, c1);
        pulse(1'b0);
        wait_for(1'b0, 1'b1, 4);
        repeat (5000) @(posedge clock_i);
        rd(8'h2f, c2);
        check("count in halt", {25'h0, 7'(c1[6:0] - 7'(dec))}, {25'h0, c2[6:0]});
        rd(8'h31, st);
        check("status in halt", st_halt, st);
        pulse(1'b1);
        wait_for(1'b0, 1'b0, 4);
        rd(8'h31, st);
        check("status after wake", st_wake, st);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        reset_i = 1'b1;
        reg_write_i = 1'b0;
        reg_read_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        time_base_select_i = 2'h0;
        time_base_irq_enable_i = 1'b0;
        halt_reset_option_i = 1'b0;
        hw_watchdog_option_i = 1'b0;
        long_restart_delay_i = 1'b0;
        halt_request_i = 1'b0;
        wake_irq_i = 1'b0;
        do_reset(1'b0, 1'b0);
        rd(8'h2f, st);
        check("control after reset", 8'h7f, st);
        rd(8'h30, st);
        check("window after reset", 8'h7f, st);
        wr(8'h00, 8'ha5);
        rd(8'h00, st);
        check("unmapped read", 8'h00, st);
        check("reset pin idle", 1, reset_pin_n_o);
        // Knee counts, zero, full scale, then random counts for every time base.
        for (int i = 0; i < 20; i++) begin
            time_base_select_i <= 2'(i % 4);
            cnt = i < 4 ? msb_tab[i] / 4 : (i < 8 ? 0 : (i < 12 ? 63 : $random(seed) & 63));
            wr(8'h2f, 8'h40 | 8'(cnt));
            rd(8'h2f, c1);
            for (int j = 0; j < 6; j++) begin
                rd(8'(8'h32 + j), st);
                bb[8 * j +: 8] = st;
            end
            rd(8'h2f, c2);
            if (c1 === c2) begin
                check("min timeout", bound(i % 4, int'(c1[5:0]), 1'b0), {8'h0, bb[23:0]});
                check("max timeout", bound(i % 4, int'(c1[5:0]), 1'b1), {8'h0, bb[47:24]});
            end
        end
        halt_cycle(1'b0, 8'h04, 8'h01, 1);
        repeat (300) @(posedge clock_i);
        halt_cycle(1'b1, 8'h02, 8'h00, 0);
        wr(8'h2f, 8'hff);
        wr(8'h2f, 8'h7f);
        rd(8'h2f, st);
        check("activation kept", 1, {31'h0, st[7]});
        wr(8'h30, 8'h50);
        rd(8'h30, st);
        check("window value", 8'h50, st);
        wr(8'h2f, 8'hff);
        expect_fire(4);
        wr(8'h30, 8'h7f);
        wr(8'h2f, 8'hc1);
        wait_for(1'b1, 1'b0, 9000);
        rd(8'h2f, st);
        check("count after roll", 8'hbf, st);
        repeat (400) @(posedge clock_i);
        wr(8'h2f, 8'hbf);
        expect_fire(4);
        do_reset(1'b0, 1'b0);
        rd(8'h2f, st);
        check("activation cleared", 0, {31'h0, st[7]});
        do_reset(1'b1, 1'b1);
        rd(8'h31, st);
        check("status long wait", 8'h09, st);
        repeat (4000) @(posedge clock_i);
        rd(8'h31, st);
        check("status running", 8'h08, st);
        wr(8'h2f, 8'h3f);
        expect_fire(4);
        halt_reset_option_i <= 1'b1;
        time_base_irq_enable_i <= 1'b0;
        pulse(1'b0);
        expect_fire(4);
        check("no halt on halt reset", 0, {31'h0, halt_entered_o});
        stop_test();
    end
endmodule
